// file: logic/core_regs_pkg.sv
/*
  Package for the CPU status, core control and register-set context block.
  Holds register indices, bit positions, reset values and the carrier
  structs shared by the register block and its flag-update helper.
  Assumes a single core clock domain; the CPU reaches the registers by
  register index over its own internal data path.
*/
package core_regs_pkg;

  // --------------------------------------------------------------------
  // Register indices (internal selects, not bus addresses)
  // --------------------------------------------------------------------
  localparam logic [1:0] IDX_CPU_FLAGS = 2'h0;
  localparam logic [1:0] IDX_CORE_CTRL = 2'h1;
  localparam logic [1:0] IDX_REG_SET = 2'h2;

  // --------------------------------------------------------------------
  // Status register bit positions
  // --------------------------------------------------------------------
  localparam int B_ACC_A_OVF = 15;
  localparam int B_ACC_B_OVF = 14;
  localparam int B_ACC_A_CLIP = 13;
  localparam int B_ACC_B_CLIP = 12;
  localparam int B_ANY_OVF = 11;
  localparam int B_ANY_CLIP = 10;
  localparam int B_LOOP_ACTIVE = 9;
  localparam int B_HALF_CARRY = 8;
  localparam int B_PRIO_HI = 7;
  localparam int B_PRIO_LO = 5;
  localparam int B_RPT_ON = 4;
  localparam int B_NEG = 3;
  localparam int B_SWRAP = 2;
  localparam int B_ZERO = 1;
  localparam int B_CARRY = 0;

  // --------------------------------------------------------------------
  // Core control bit positions and reset value
  // --------------------------------------------------------------------
  localparam int B_EXC_LAT = 15;
  localparam int B_MULT_HI = 13;
  localparam int B_MULT_LO = 12;
  localparam int B_EARLY_EXIT = 11;
  localparam int B_DEPTH_HI = 10;
  localparam int B_DEPTH_LO = 8;
  localparam int B_A_CLIP_EN = 7;
  localparam int B_B_CLIP_EN = 6;
  localparam int B_STORE_CLIP = 5;
  localparam int B_CLIP_WIDTH = 4;
  localparam int B_PRIO_MSB = 3;
  localparam int B_STACK_FRAME = 2;
  localparam int B_ROUND = 1;
  localparam int B_INT_FRAC = 0;

  // Context status fields
  localparam int B_CUR_SET_HI = 10;
  localparam int B_CUR_SET_LO = 8;
  localparam int B_MAN_SET_HI = 2;
  localparam int B_MAN_SET_LO = 0;

  localparam logic [15:0] CPU_FLAGS_RST = 16'h0000;
  localparam logic [15:0] CORE_CTRL_RST = 16'h0020;
  localparam logic [15:0] REG_SET_RST = 16'h0000;

  // Writable masks (read-only and derived bits excluded, except stack frame bit 2)
  localparam logic [15:0] CORE_CTRL_WMASK = 16'hb0f7;
  localparam logic [2:0] SET_ID_MAX = 3'h2;

  // --------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {MULT_SIGNED, MULT_UNSIGNED, MULT_MIXED,
                            MULT_RSVD} mult_mode_t;

  // One ALU result update, valid when upd is high
  typedef struct packed {
    logic upd;        // Flag update strobe
    logic byte_op;    // Byte-sized operation
    logic sub_op;     // Subtraction (carries are borrows)
    logic [15:0] a;   // First operand
    logic [15:0] b;   // Second operand (as presented to adder)
    logic [16:0] sum; // Adder result with carry-out
    logic upd_c;      // Operation affects carry
    logic upd_z;      // Operation affects zero
    logic upd_n;      // Operation affects negative
    logic upd_ov;     // Operation affects signed overflow
    logic upd_dc;     // Operation affects half carry
  } alu_result_t;

  // Decoded flags produced by the helper
  typedef struct packed {
    logic carry;
    logic zero_res;
    logic neg;
    logic swrap;
    logic half_carry;
  } alu_flags_t;

  // DSP engine, loop and context events
  typedef struct packed {
    logic acc_a_ovf;     // Accumulator A currently overflowed
    logic acc_b_ovf;     // Accumulator B currently overflowed
    logic acc_a_sat;     // Accumulator A saturated this cycle
    logic acc_b_sat;     // Accumulator B saturated this cycle
    logic do_active;     // DO loop in progress
    logic rpt_active;    // REPEAT loop in progress
    logic [2:0] do_depth;// Active DO nesting count
    logic frame_set;     // Stack frame becomes active
    logic frame_clr;     // Stack frame ends
    logic prio_msb_set;  // Priority level raised above 7
    logic [2:0] prio_set;// Priority value loaded by hardware
    logic prio_load;     // Load strobe for prio_set
    logic [2:0] cur_set; // Register set now in use
    logic man_sel;       // Manual set swap strobe
    logic [2:0] man_set; // Set chosen by the manual swap
  } core_events_t;

  // Mode outputs steering the DSP datapath
  typedef struct packed {
    logic exc_latency_mode;
    mult_mode_t mult_signedness;
    logic acc_a_clip_en;
    logic acc_b_clip_en;
    logic store_clip_en;
    logic clip_width_sel;
    logic round_mode;
    logic int_frac_sel;
    logic stack_frame_flag;
    logic early_loop_exit;
    logic user_irq_off;
    logic [3:0] cpu_prio;
  } core_modes_t;

endpackage

// file: logic/alu_flag_calc.sv
/*
  Flag decoder for one ALU result: carry, zero, negative, signed overflow
  and half carry for byte or word operations.
  Assumes the caller presents operands and the 17-bit sum of one addition
  (subtraction as a + ~b + 1); purely combinational.
*/
`timescale 1ns/1ps
module alu_flag_calc
  import core_regs_pkg::*;
(
  input wire alu_result_t res, // Operation and result
  output alu_flags_t flags     // Decoded flag values
);

  logic [3:0] lo_nib;
  logic [7:0] lo_byte;
  logic [4:0] nib_sum;
  logic [8:0] byte_sum;
  logic msb_a;
  logic msb_b;
  logic msb_r;

  // --------------------------------------------------------------------
  // Partial sums for half carry and byte-sized carry
  // --------------------------------------------------------------------
  always_comb begin
    lo_nib = res.a[3:0];
    lo_byte = res.a[7:0];
    nib_sum = {1'b0, lo_nib} + {1'b0, res.b[3:0]} + {4'h0, res.sub_op};
    byte_sum = {1'b0, lo_byte} + {1'b0, res.b[7:0]} + {8'h00, res.sub_op};
  end

  // Sign bits of the operation width
  always_comb begin
    msb_a = res.byte_op ? res.a[7] : res.a[15];
    msb_b = res.byte_op ? res.b[7] : res.b[15];
    msb_r = res.byte_op ? res.sum[7] : res.sum[15];
  end

  // Flags; subtraction carry is a borrow, so active carry means no borrow
  always_comb begin
    flags.carry = res.byte_op ? byte_sum[8] : res.sum[16];
    flags.half_carry = res.byte_op ? nib_sum[4] : byte_sum[8];
    flags.neg = msb_r;
    flags.swrap = (msb_a == msb_b) && (msb_r != msb_a);
    flags.zero_res = res.byte_op ? (res.sum[7:0] == 8'h00)
                                 : (res.sum[15:0] == 16'h0000);
  end

endmodule

// file: logic/core_status_regs.sv
/*
  CPU status, core control and register-set context registers.
  Holds the flag register, the DSP/loop control register and the context
  status register, updated by CPU register writes and by datapath events.
  Assumes the CPU drives one register access per cycle over its internal
  path, and the ALU, DSP engine and interrupt controller run on clk.
*/
`timescale 1ns/1ps

module core_status_regs
  import core_regs_pkg::*;
(
  input wire logic clk,                // Core clock, 200 MHz
  input wire logic rst_b,              // Asynchronous reset, active low
  input wire logic wr_en,              // CPU register write strobe
  input wire logic [1:0] wr_idx,       // Register index for the write
  input wire logic [15:0] wr_data,     // Write data
  input wire logic [1:0] rd_idx,       // Register index for reads
  output logic [15:0] rd_data,         // Read data, combinational mux
  input wire logic nesting_off,        // Interrupt nesting disabled
  input wire alu_result_t alu_res,     // ALU result for flag update
  input wire core_events_t ev,         // DSP, loop and context events
  output core_modes_t modes,           // Mode bits to the datapath
  output logic [15:0] cpu_flags_reg,   // Status register image
  output logic [15:0] core_ctrl_reg,   // Control register image
  output logic [15:0] reg_set_status_reg // Context status image
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic acc_a_ovf_flag;
  logic acc_b_ovf_flag;
  logic acc_a_clip_sticky;
  logic acc_b_clip_sticky;
  logic loop_active;
  logic rpt_loop_on;
  logic half_carry;
  logic [2:0] cpu_prio_level;
  logic neg_flag;
  logic signed_wrap_flag;
  logic zero_flag;
  logic carry_flag;
  logic [15:0] ctrl_rw_reg;
  logic early_exit_reg;
  logic [2:0] loop_nest_depth;
  logic prio_level_msb;
  logic stack_frame_flag;
  logic [2:0] current_reg_set_id;
  logic [2:0] manual_reg_set_id;
  alu_flags_t alu_flags;
  logic wr_flags;
  logic wr_ctrl;
  logic wr_ctx;
  logic user_irq_block;

  // Register write decode; index 3 selects nothing and is dropped
  always_comb begin
    wr_flags = wr_en && (wr_idx == IDX_CPU_FLAGS);
    wr_ctrl = wr_en && (wr_idx == IDX_CORE_CTRL);
    wr_ctx = wr_en && (wr_idx == IDX_REG_SET);
  end

  // ALU flag decode lives in its own module to keep width logic apart
  alu_flag_calc u_flags (
    .res   (alu_res),
    .flags (alu_flags)
  );

  // --------------------------------------------------------------------
  // Accumulator overflow: live status, software writes are ignored and the
  // datapath level is loaded every cycle since it reflects the present accumulator state
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_ovf_flag <= 1'b0;
      acc_b_ovf_flag <= 1'b0;
    end else begin
      acc_a_ovf_flag <= ev.acc_a_ovf;
      acc_b_ovf_flag <= ev.acc_b_ovf;
    end
  end

  // Sticky saturation; a new saturation beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_clip_sticky <= 1'b0;
      acc_b_clip_sticky <= 1'b0;
    end else begin
      if (ev.acc_a_sat) begin
        acc_a_clip_sticky <= 1'b1;
      end else if (wr_flags) begin
        // Direct write, or clearing the combined bit drops both
        acc_a_clip_sticky <= wr_data[B_ACC_A_CLIP] &&
                             wr_data[B_ANY_CLIP];
      end
      if (ev.acc_b_sat) begin
        acc_b_clip_sticky <= 1'b1;
      end else if (wr_flags) begin
        acc_b_clip_sticky <= wr_data[B_ACC_B_CLIP] &&
                             wr_data[B_ANY_CLIP];
      end
    end
  end

  // Loop activity is a read-only image of the sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_active <= 1'b0;
      rpt_loop_on <= 1'b0;
      loop_nest_depth <= 3'h0;
    end else begin
      loop_active <= ev.do_active;
      rpt_loop_on <= ev.rpt_active;
      loop_nest_depth <= ev.do_depth;
    end
  end

  // --------------------------------------------------------------------
  // ALU flags: an ALU update in the same cycle as a write wins, since
  // the instruction retiring later in program order owns the result.
  // The merge is per bit, so a write cannot pre-load a flag that the
  // same cycle's update also touches
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      neg_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      half_carry <= 1'b0;
    end else begin
      if (wr_flags) begin
        carry_flag <= wr_data[B_CARRY];
        zero_flag <= wr_data[B_ZERO];
        neg_flag <= wr_data[B_NEG];
        signed_wrap_flag <= wr_data[B_SWRAP];
        half_carry <= wr_data[B_HALF_CARRY];
      end
      if (alu_res.upd) begin
        if (alu_res.upd_c) begin
          carry_flag <= alu_flags.carry;
        end
        if (alu_res.upd_z && !alu_flags.zero_res) begin
          zero_flag <= 1'b0;
        end else if (alu_res.upd_z) begin
          zero_flag <= 1'b1;
        end
        if (alu_res.upd_n) begin
          neg_flag <= alu_flags.neg;
        end
        if (alu_res.upd_ov) begin
          signed_wrap_flag <= alu_flags.swrap;
        end
        if (alu_res.upd_dc) begin
          half_carry <= alu_flags.half_carry;
        end
      end
    end
  end

  // Priority level bits; locked against software while nesting is off.
  // The controller's load wins over a software write: it marks an
  // exception entry or return that is already under way
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_prio_level <= 3'h0;
    end else if (ev.prio_load) begin
      cpu_prio_level <= ev.prio_set;
    end else if (wr_flags && !nesting_off) begin
      cpu_prio_level <= wr_data[B_PRIO_HI:B_PRIO_LO];
    end
  end

  // --------------------------------------------------------------------
  // Core control: plain read/write mode bits
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_rw_reg <= CORE_CTRL_RST & CORE_CTRL_WMASK;
    end else if (wr_ctrl) begin
      ctrl_rw_reg <= wr_data & CORE_CTRL_WMASK;
    end
  end

  // Early exit is a one-cycle command; it never stores
  // The loop sequencer must act on the pulse in the cycle it stands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      early_exit_reg <= 1'b0;
    end else begin
      early_exit_reg <= wr_ctrl && wr_data[B_EARLY_EXIT];
    end
  end

  // Priority msb: hardware sets it, software may only clear it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_level_msb <= 1'b0;
    end else if (ev.prio_msb_set) begin
      prio_level_msb <= 1'b1;
    end else if (wr_ctrl && !wr_data[B_PRIO_MSB]) begin
      prio_level_msb <= 1'b0;
    end
  end

  // Stack frame status follows frame entry and exit
  // Entry wins over a same-cycle exit, so a new frame is never lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_frame_flag <= 1'b0;
    end else if (ev.frame_set) begin
      stack_frame_flag <= 1'b1;
    end else if (ev.frame_clr) begin
      stack_frame_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Register set context; reserved codes are never stored
  // A reserved code keeps the previous identifier rather than showing
  // a value that software could mistake for a real register set
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      current_reg_set_id <= 3'h0;
      manual_reg_set_id <= 3'h0;
    end else begin
      if (ev.cur_set <= SET_ID_MAX) begin
        current_reg_set_id <= ev.cur_set;
      end
      if (ev.man_sel && ev.man_set <= SET_ID_MAX) begin
        manual_reg_set_id <= ev.man_set;
      end else if (wr_ctx && wr_data[B_MAN_SET_HI:B_MAN_SET_LO] <=
                   SET_ID_MAX) begin
        manual_reg_set_id <= wr_data[B_MAN_SET_HI:B_MAN_SET_LO];
      end
    end
  end

  // --------------------------------------------------------------------
  // Register images
  // --------------------------------------------------------------------
  // Status image; the combined bits have no storage and are rebuilt here
  always_comb begin
    cpu_flags_reg = CPU_FLAGS_RST;
    cpu_flags_reg[B_ACC_A_OVF] = acc_a_ovf_flag;
    cpu_flags_reg[B_ACC_B_OVF] = acc_b_ovf_flag;
    cpu_flags_reg[B_ACC_A_CLIP] = acc_a_clip_sticky;
    cpu_flags_reg[B_ACC_B_CLIP] = acc_b_clip_sticky;
    cpu_flags_reg[B_ANY_OVF] = acc_a_ovf_flag | acc_b_ovf_flag;
    cpu_flags_reg[B_ANY_CLIP] = acc_a_clip_sticky |
                                acc_b_clip_sticky;
    cpu_flags_reg[B_LOOP_ACTIVE] = loop_active;
    cpu_flags_reg[B_HALF_CARRY] = half_carry;
    cpu_flags_reg[B_PRIO_HI:B_PRIO_LO] = cpu_prio_level;
    cpu_flags_reg[B_RPT_ON] = rpt_loop_on;
    cpu_flags_reg[B_NEG] = neg_flag;
    cpu_flags_reg[B_SWRAP] = signed_wrap_flag;
    cpu_flags_reg[B_ZERO] = zero_flag;
    cpu_flags_reg[B_CARRY] = carry_flag;
  end

  // Early exit reads zero; depth and frame are read-only images
  always_comb begin
    core_ctrl_reg = ctrl_rw_reg;
    core_ctrl_reg[B_EARLY_EXIT] = 1'b0;
    core_ctrl_reg[B_DEPTH_HI:B_DEPTH_LO] = loop_nest_depth;
    core_ctrl_reg[B_PRIO_MSB] = prio_level_msb;
    core_ctrl_reg[B_STACK_FRAME] = stack_frame_flag;
  end

  // Context image; the unimplemented bits read zero
  always_comb begin
    reg_set_status_reg = REG_SET_RST;
    reg_set_status_reg[B_CUR_SET_HI:B_CUR_SET_LO] = current_reg_set_id;
    reg_set_status_reg[B_MAN_SET_HI:B_MAN_SET_LO] = manual_reg_set_id;
  end

  // Read mux; the unused index reads zero
  always_comb begin
    unique case (rd_idx)
      IDX_CPU_FLAGS: rd_data = cpu_flags_reg;
      IDX_CORE_CTRL: rd_data = core_ctrl_reg;
      IDX_REG_SET: rd_data = reg_set_status_reg;
      default: rd_data = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------
  // User interrupt gate: level 7 already masks every user source, and
  // any level above 7 does too
  // --------------------------------------------------------------------
  always_comb begin
    user_irq_block = prio_level_msb || (cpu_prio_level == 3'h7);
  end

  // --------------------------------------------------------------------
  // Mode outputs to the datapath
  // --------------------------------------------------------------------
  always_comb begin
    modes.exc_latency_mode = ctrl_rw_reg[B_EXC_LAT];
    modes.mult_signedness =
      mult_mode_t'(ctrl_rw_reg[B_MULT_HI:B_MULT_LO]);
    modes.acc_a_clip_en = ctrl_rw_reg[B_A_CLIP_EN];
    modes.acc_b_clip_en = ctrl_rw_reg[B_B_CLIP_EN];
    modes.store_clip_en = ctrl_rw_reg[B_STORE_CLIP];
    modes.clip_width_sel = ctrl_rw_reg[B_CLIP_WIDTH];
    modes.round_mode = ctrl_rw_reg[B_ROUND];
    modes.int_frac_sel = ctrl_rw_reg[B_INT_FRAC];
    // Datapath ignores page registers for W14/W15 while this is high
    modes.stack_frame_flag = stack_frame_flag;
    modes.early_loop_exit = early_exit_reg;
    modes.user_irq_off = user_irq_block;
    modes.cpu_prio = {prio_level_msb, cpu_prio_level};
  end

endmodule

// file: dv/core_status_regs_assertions.sv
/*
  Checker for the status, control and context register block.
  Assumes one clk domain and the async active-low reset rst_b.
*/
`timescale 1ns/1ps
module core_status_regs_assertions
  import core_regs_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_b, // Reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [1:0] wr_idx, // Write index
  input wire logic [15:0] wr_data, // Write data
  input wire logic nesting_off, // Priority lock
  input wire alu_result_t alu_res, // ALU update
  input wire core_events_t ev, // Datapath events
  input wire core_modes_t modes, // Mode outputs
  input wire logic [15:0] cpu_flags_reg, // Status image
  input wire logic [15:0] core_ctrl_reg, // Control image
  input wire logic [15:0] reg_set_status_reg // Context image
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_any_ovf: assert property (
    cpu_flags_reg[11] == (cpu_flags_reg[15] | cpu_flags_reg[14]))
    else $error("combined overflow bit wrong");
  a_ovf_follow: assert property (
    1 |=> cpu_flags_reg[15:14] == $past({ev.acc_a_ovf, ev.acc_b_ovf}))
    else $error("overflow bits do not track datapath");
  a_any_clip: assert property (
    cpu_flags_reg[10] == (cpu_flags_reg[13] | cpu_flags_reg[12]))
    else $error("combined saturation bit wrong");
  // Sticky bit must survive any cycle without a status write
  a_sticky_hold: assert property (
    (ev.acc_a_sat || cpu_flags_reg[13] && !(wr_en && wr_idx == IDX_CPU_FLAGS))
    |=> cpu_flags_reg[13])
    else $error("sticky saturation bit lost");
  a_loop_flags: assert property (
    1 |=> {cpu_flags_reg[9], cpu_flags_reg[4]} ==
          $past({ev.do_active, ev.rpt_active}))
    else $error("loop activity bits wrong");
  a_neg_sign: assert property (
    alu_res.upd && alu_res.upd_n && !alu_res.byte_op
    |=> cpu_flags_reg[3] == $past(alu_res.sum[15]))
    else $error("negative flag differs from result sign");
  a_prio_concat: assert property (
    modes.cpu_prio == {core_ctrl_reg[3], cpu_flags_reg[7:5]} &&
    modes.user_irq_off ==
    (core_ctrl_reg[3] || cpu_flags_reg[7:5] == 3'h7))
    else $error("priority level not formed from its bits");
  a_prio_lock: assert property (
    nesting_off && !ev.prio_load |=> $stable(cpu_flags_reg[7:5]))
    else $error("locked priority bits changed");
  a_ctrl_write: assert property (
    wr_en && wr_idx == IDX_CORE_CTRL
    |=> (core_ctrl_reg & 16'hb0f3) == ($past(wr_data) & 16'hb0f3))
    else $error("control write not stored");
  a_exit_pulse: assert property (
    modes.early_loop_exit |-> !core_ctrl_reg[11] &&
    $past(wr_en && wr_idx == IDX_CORE_CTRL && wr_data[11]))
    else $error("early exit without its write");
  a_depth_ro: assert property (
    1 |=> core_ctrl_reg[10:8] == $past(ev.do_depth))
    else $error("nesting depth field wrong");
  a_set_ids: assert property (
    (reg_set_status_reg & 16'hf8f8) == 16'h0000 &&
    reg_set_status_reg[2:0] <= SET_ID_MAX &&
    reg_set_status_reg[10:8] <= SET_ID_MAX)
    else $error("context identifier out of range");

  c_sat: cover property (ev.acc_b_sat ##1 cpu_flags_reg[12]);
  c_lock: cover property (nesting_off && wr_en && wr_idx == IDX_CPU_FLAGS);
  c_exit: cover property (modes.early_loop_exit);
endmodule

bind core_status_regs core_status_regs_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_idx(wr_idx),
  .wr_data(wr_data), .nesting_off(nesting_off), .alu_res(alu_res),
  .ev(ev), .modes(modes), .cpu_flags_reg(cpu_flags_reg),
  .core_ctrl_reg(core_ctrl_reg), .reg_set_status_reg(reg_set_status_reg)
);

// file: dv/core_status_regs_tb.sv
/*
  Directed testbench for the status, control and context registers.
  Assumes the checker is bound; drives all inputs 1 ns after clk rises.
*/
`timescale 1ns/1ps
module core_status_regs_tb
  import core_regs_pkg::*;
;
  logic clk, rst_b, wr_en, nesting_off;
  logic [1:0] wr_idx, rd_idx;
  logic [15:0] wr_data, rd_data, flags, ctrl, rset;
  alu_result_t alu_res;
  core_events_t ev;
  core_modes_t modes;
  int checks, bad_count;

  core_status_regs dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx), .rd_data(rd_data),
    .nesting_off(nesting_off), .alu_res(alu_res), .ev(ev), .modes(modes),
    .cpu_flags_reg(flags), .core_ctrl_reg(ctrl), .reg_set_status_reg(rset));

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  // One-cycle write pulse; returns just after the storing edge
  task wr(input logic [1:0] idx, input logic [15:0] d);
    step;
    wr_en = 1;
    wr_idx = idx;
    wr_data = d;
    step;
    wr_en = 0;
  endtask

  // Select set just after an edge; returns just after the next edge
  task rd(input logic [1:0] idx, input logic [15:0] exp);
    rd_idx = idx;
    #1;
    chk(rd_data, exp);
    step;
  endtask

  // Subtraction is presented as a + ~b + 1, as the adder sees it
  task alu(input logic [15:0] a, b, input logic sub, byt, uz,
           input logic [15:0] exp);
    logic [15:0] bb;
    bb = sub ? ~b : b;
    step;
    alu_res = '0;
    alu_res.upd = 1;
    alu_res.byte_op = byt;
    alu_res.sub_op = sub;
    alu_res.a = a;
    alu_res.b = bb;
    alu_res.sum = {1'b0, a} + {1'b0, bb} + 17'(sub);
    {alu_res.upd_c, alu_res.upd_n, alu_res.upd_ov, alu_res.upd_dc} = 4'hf;
    alu_res.upd_z = uz;
    step;
    alu_res = '0;
    rd(IDX_CPU_FLAGS, exp);
  endtask

  task end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog in case the sequence hangs
  initial begin
    #100us;
    bad_count++;
    end_of_test;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_b, wr_en, wr_idx, wr_data, rd_idx, nesting_off} = '0;
    alu_res = '0;
    ev = '0;
    checks = 0;
    bad_count = 0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    rd(IDX_CPU_FLAGS, 16'h0000);
    rd(IDX_CORE_CTRL, 16'h0020);
    rd(IDX_REG_SET, 16'h0000);
    rd(2'h3, 16'h0000);
    $display("test reset done");
    ev.do_depth = 3'h5;
    wr(IDX_CORE_CTRL, 16'hfffb);
    chk(16'(modes.early_loop_exit), 16'h0001);
    rd(IDX_CORE_CTRL, 16'hb5f3);
    chk({9'h0, modes.exc_latency_mode, modes.acc_a_clip_en,
      modes.acc_b_clip_en, modes.store_clip_en, modes.clip_width_sel,
      modes.round_mode, modes.int_frac_sel}, 16'h007f);
    step;
    chk(16'(modes.early_loop_exit), 16'h0000);
    ev.do_depth = 3'h0;
    wr(IDX_CORE_CTRL, 16'h0000);
    rd(IDX_CORE_CTRL, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(IDX_CORE_CTRL, 16'(m) << 12);
      chk(16'(modes.mult_signedness), 16'(m));
    end
    $display("test control done");
    ev.acc_a_ovf = 1;
    ev.do_active = 1;
    ev.rpt_active = 1;
    step;
    rd(IDX_CPU_FLAGS, 16'h8a10);
    wr(IDX_CPU_FLAGS, 16'h0000);
    rd(IDX_CPU_FLAGS, 16'h8a10);
    ev = '0;
    ev.acc_b_ovf = 1;
    step;
    rd(IDX_CPU_FLAGS, 16'h4800);
    ev = '0;
    ev.acc_b_sat = 1;
    step;
    ev.acc_b_sat = 0;
    repeat (3) step;
    rd(IDX_CPU_FLAGS, 16'h1400);
    wr(IDX_CPU_FLAGS, 16'h2400);
    rd(IDX_CPU_FLAGS, 16'h2400);
    wr(IDX_CPU_FLAGS, 16'h3000);
    rd(IDX_CPU_FLAGS, 16'h0000);
    $display("test accumulator flags done");
    alu(16'h00ff, 16'h0001, 0, 0, 1, 16'h0100);
    alu(16'h7fff, 16'h0001, 0, 0, 1, 16'h010c);
    alu(16'hffff, 16'h0001, 0, 0, 1, 16'h0103);
    alu(16'h0001, 16'h0001, 0, 0, 0, 16'h0002);
    alu(16'h000f, 16'h0001, 0, 1, 1, 16'h0100);
    alu(16'h0001, 16'h0002, 1, 0, 1, 16'h0008);
    $display("test alu flags done");
    wr(IDX_CPU_FLAGS, 16'h00e0);
    chk(16'(modes.cpu_prio), 16'h0007);
    chk(16'(modes.user_irq_off), 16'h0001);
    nesting_off = 1;
    wr(IDX_CPU_FLAGS, 16'h0000);
    rd(IDX_CPU_FLAGS, 16'h00e0);
    ev.prio_msb_set = 1;
    step;
    ev.prio_msb_set = 0;
    chk(16'({modes.user_irq_off, modes.cpu_prio}), 16'h001f);
    rd(IDX_CORE_CTRL, 16'h2008);
    wr(IDX_CORE_CTRL, 16'h2000);
    rd(IDX_CORE_CTRL, 16'h2000);
    ev.prio_load = 1;
    ev.prio_set = 3'h3;
    step;
    ev.prio_load = 0;
    rd(IDX_CPU_FLAGS, 16'h0060);
    ev.frame_set = 1;
    step;
    ev.frame_set = 0;
    chk(16'(modes.stack_frame_flag), 16'h0001);
    rd(IDX_CORE_CTRL, 16'h2004);
    ev.frame_clr = 1;
    step;
    ev.frame_clr = 0;
    rd(IDX_CORE_CTRL, 16'h2000);
    nesting_off = 0;
    $display("test priority done");
    ev.cur_set = 3'h2;
    step;
    rd(IDX_REG_SET, 16'h0200);
    wr(IDX_REG_SET, 16'h0001);
    rd(IDX_REG_SET, 16'h0201);
    wr(IDX_REG_SET, 16'h0007);
    rd(IDX_REG_SET, 16'h0201);
    ev.man_sel = 1;
    ev.man_set = 3'h2;
    step;
    ev.man_sel = 0;
    ev.cur_set = 3'h3;
    step;
    rd(IDX_REG_SET, 16'h0202);
    $display("test register sets done");
    end_of_test;
  end
endmodule
